//--- phs_map_enc.sv
// Purpose: Binary-tree coding of a 16-bit quarter-core hit map
// Assumes: Map bit 15 is the top-left pixel, bit 0 the bottom-right
// Notes: Combinational; result left-aligned, length up to 30
module phs_map_enc
  import phs_pkg::*;
(
  phs_map_if.enc m
);
  // Append one tree element, 01 shortened to a single 0
  function automatic logic [34:0] put2(logic [29:0] c, logic [4:0] n, logic [1:0] v);
    if (v == 2'b01) begin
      return {c, 5'(n + 5'h01)};
    end
    return {c | ({v, 28'h0} >> n), 5'(n + 5'h02)};
  endfunction

  // Depth-first tree walk, one row complete before the next
  always_comb begin
    logic [29:0] c;
    logic [4:0] n;
    logic [1:0] rows;
    logic [7:0] row;
    logic [1:0] hv;
    logic [3:0] half;
    logic [1:0] pv;
    c = '0;
    n = '0;
    rows = {|m.map[15:8], |m.map[7:0]};
    row = '0;
    hv = '0;
    half = '0;
    pv = '0;
    if (!m.compress) begin
      c = {m.map, 14'h0};
      n = PHS_RAW_LEN;
    end else begin
      {c, n} = put2(c, n, rows);
      for (int r = 0; r < 2; r++) begin
        if (rows[1-r]) begin
          row = m.map[15-8*r -: 8];
          hv = {|row[7:4], |row[3:0]};
          {c, n} = put2(c, n, hv);
          for (int h = 0; h < 2; h++) begin
            if (hv[1-h]) begin
              half = row[7-4*h -: 4];
              {c, n} = put2(c, n, {|half[3:2], |half[1:0]});
            end
          end
          for (int h = 0; h < 2; h++) begin
            half = row[7-4*h -: 4];
            pv = {|half[3:2], |half[1:0]};
            for (int p = 0; p < 2; p++) begin
              if (hv[1-h] && pv[1-p]) begin
                {c, n} = put2(c, n, half[3-2*p -: 2]);
              end
            end
          end
        end
      end
    end
    m.code = c;
    m.len = n;
  end
endmodule

//--- phs_map_if.sv
// Purpose: Carries a quarter-core map to the map coder and its code back
// Assumes: Purely combinational path inside one clock domain
// Notes: Code is left-aligned in code, length in len
interface phs_map_if;
  logic [15:0] map;
  logic compress;
  logic [29:0] code;
  logic [4:0] len;
  modport enc (input map, input compress, output code, output len);
  modport user (output map, output compress, input code, input len);
endinterface

//--- phs_pkg.sv
// Purpose: Shared constants for the pixel hit stream encoder
// Assumes: One core clock, AXI4-Lite register access with 32-bit data
// Notes: Functional notes below, one line per behaviour
// Functional notes
// - Hits addressed by column, quarter-row, 2x8 map
// - Widths follow map, top row first, left-right
// - 4-bit widths; suppress option drops them all
// - Final-row flag set only on column's last row
// - Adjacent-row flag replaces row number when consecutive
// - Column address six bits, only 1..55
// - Internal tag is 111 plus eight bits
// - Column may resume later, adjacent flag does not continue
// - Stream ends at event limit or idle input
// - Trailing block bits after stream are zeros
// - Marker on: at least six trailing zeros
// - First block of stream has start bit set
// - Map bit is one where width is not 1111
// - Compression default on; off gives raw 16 bits
// - Tree level one: top then bottom row bits
// - Half-row bits, pair bits, then pair maps
// - Tree emitted depth-first, one row at a time
// - Every 2-bit code 01 becomes single 0
// - Each 64-bit block begins with stream start bit
// - New stream opens with 8-bit event tag
// - End marker is six zeros, can be disabled
package phs_pkg;
  // Register map (byte addresses)
  localparam logic [7:0] PHS_ADDR_CONF = 8'h00;
  localparam logic [7:0] PHS_ADDR_STAT = 8'h04;
  // Settings register fields
  localparam int PHS_CONF_COMPRESS = 0;
  localparam int PHS_CONF_SUPPRESS = 1;
  localparam int PHS_CONF_MARKER = 2;
  localparam int PHS_CONF_NE_LSB = 8;
  localparam logic PHS_RST_COMPRESS = 1'b1;
  localparam logic PHS_RST_SUPPRESS = 1'b0;
  localparam logic PHS_RST_MARKER = 1'b1;
  localparam logic [5:0] PHS_RST_NE = 6'h10;
  // Status register fields
  localparam int PHS_STAT_BUSY = 0;
  localparam int PHS_STAT_CNT_LSB = 16;
  // Field widths and codes
  localparam int PHS_CCOL_W = 6;
  localparam int PHS_QROW_W = 8;
  localparam int PHS_TAG_W = 8;
  localparam int PHS_TOT_W = 4;
  localparam logic [2:0] PHS_ITAG_PFX = 3'h7;
  localparam logic [5:0] PHS_CCOL_MAX = 6'h37;
  localparam logic [3:0] PHS_TOT_NOHIT = 4'hF;
  localparam logic [4:0] PHS_RAW_LEN = 5'h10;
  localparam logic [4:0] PHS_CODE_W = 5'h1E;
  localparam logic [7:0] PHS_EOS_LEN = 8'h06;
  localparam logic [6:0] PHS_PAY_W = 7'h3F;
  localparam logic [7:0] PHS_PEND_W = 8'h80;
  // AXI responses
  localparam logic [1:0] PHS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PHS_RESP_SLVERR = 2'h2;
  // Encoder states
  typedef enum logic [1:0] {
    PHS_IDLE = 2'b00,
    PHS_RUN = 2'b01,
    PHS_CLOSE = 2'b10
  } phs_st_t;
endpackage

//--- phs_sink_model.sv
// Purpose: Block sink standing in for the off-detector stream decoder
// Assumes: Blocks are kept whole; the bench compares them whole against its expected blocks
// Notes: Stall mode grants ready one cycle in four
module phs_sink_model (
  input wire logic clock_in,
  input wire logic blk_valid_in,
  input wire logic [63:0] blk_data_in,
  input wire logic stall_in,
  output logic blk_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] blks[$];
  logic [1:0] cnt = 2'h0;
  initial blk_ready_out = 1'h0;
  // Collect each block, orphan bits left for the bench to judge
  always @(posedge clock_in) begin
    cnt <= cnt + 2'h1;
    blk_ready_out <= !stall_in || cnt == 2'h3;
    if (blk_valid_in && blk_ready_out) blks.push_back(blk_data_in);
  end
endmodule

//--- phs_stream_enc.sv
// Purpose: Packs tags and hit quarter-cores into 64-bit stream blocks
// Assumes: Every event starts with a tag item; event_end marks its last item
// Notes: Block bit 63 is the stream start bit, payload bits 62..0
//
// Local design decisions: register access over AXI4-Lite and the address map.
module phs_stream_enc
  import phs_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Item input from the column readout
  input wire logic item_valid_in,
  output logic item_ready_out,
  input wire logic item_is_tag_in,
  input wire logic item_event_end_in,
  input wire logic [7:0] item_tag_in,
  input wire logic [5:0] item_ccol_in,
  input wire logic [7:0] item_qrow_in,
  input wire logic item_col_last_in,
  input wire logic [63:0] item_tot_in,
  // Block output
  output logic blk_valid_out,
  input wire logic blk_ready_in,
  output logic [63:0] blk_data_out,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  typedef struct packed {
    phs_st_t st;
    logic [127:0] pend;
    logic [7:0] plen;
    logic [62:0] blk;
    logic [6:0] fill;
    logic first;
    logic ovalid;
    logic [63:0] odata;
    logic [5:0] cur_ccol;
    logic col_open;
    logic [7:0] prev_qrow;
    logic prev_ok;
    logic evt_done;
    logic [6:0] evcnt;
    logic [15:0] nstreams;
    logic compress;
    logic suppress;
    logic marker;
    logic [5:0] ne;
    logic aw_done;
    logic [7:0] awaddr;
    logic w_done;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } phs_state_t;

  phs_state_t r;
  phs_state_t n;
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic take;
  logic close_now;
  logic new_col;
  logic nbr;
  logic col_ok;
  logic can_emit;
  logic [6:0] limit;
  logic [15:0] hit_map;
  phs_map_if hm ();

  // Append n low bits of v after the first l bits of a
  function automatic logic [135:0] app(logic [127:0] a, logic [7:0] l, logic [63:0] v,
                                       logic [6:0] nb);
    logic [127:0] t;
    t = {64'h0, v} << 8'(PHS_PEND_W - l - {1'b0, nb});
    return {a | t, 8'(l + {1'b0, nb})};
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Hit map from widths, all-ones means no hit
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      hit_map[15-i] = item_tot_in[63-4*i -: 4] != PHS_TOT_NOHIT;
    end
  end
  assign hm.map = hit_map;
  assign hm.compress = r.compress;

  phs_map_enc u_map (
    .m(hm)
  );

  // Input decisions
  assign limit = (r.ne == 6'h00) ? 7'h01 : {1'b0, r.ne};
  assign new_col = !r.col_open || (item_ccol_in != r.cur_ccol);
  assign nbr = !new_col && r.prev_ok && (item_qrow_in == 8'(r.prev_qrow + 8'h01));
  assign col_ok = (item_ccol_in != 6'h00) && (item_ccol_in <= PHS_CCOL_MAX);
  assign close_now = (r.st == PHS_RUN) && r.evt_done && (r.plen == 8'h00) &&
                     (!item_valid_in || (item_is_tag_in && (r.evcnt >= limit)));
  assign item_ready_out = (r.plen == 8'h00) &&
                          (((r.st == PHS_IDLE) && item_is_tag_in) ||
                           ((r.st == PHS_RUN) && !close_now));
  assign take = item_valid_in && item_ready_out;
  assign can_emit = !r.ovalid || blk_ready_in;

  // AXI handshake outputs
  assign s_axi_awready_out = !r.aw_done && !r.bvalid;
  assign s_axi_wready_out = !r.w_done && !r.bvalid;
  assign s_axi_arready_out = !r.rvalid;
  assign s_axi_bvalid_out = r.bvalid;
  assign s_axi_bresp_out = r.bresp;
  assign s_axi_rvalid_out = r.rvalid;
  assign s_axi_rdata_out = r.rdata;
  assign s_axi_rresp_out = r.rresp;
  assign blk_valid_out = r.ovalid;
  assign blk_data_out = r.odata;

  // Next state of the whole block
  always_comb begin
    logic [127:0] acc;
    logic [7:0] al;
    logic [6:0] space;
    logic [7:0] tk;
    acc = '0;
    al = '0;
    space = '0;
    tk = '0;
    n = r;
    // Output block taken by the sink
    if (r.ovalid && blk_ready_in) begin
      n.ovalid = 1'b0;
    end
    // Move pending bits into the block, MSB first
    space = 7'(PHS_PAY_W - r.fill);
    tk = (r.plen < {1'b0, space}) ? r.plen : {1'b0, space};
    n.blk = r.blk | 63'(r.pend[127:65] >> r.fill);
    n.pend = r.pend << tk;
    n.plen = 8'(r.plen - tk);
    n.fill = 7'(r.fill + tk[6:0]);
    // Full block, or stream tail padded with zeros
    if (can_emit && ((n.fill == PHS_PAY_W) ||
        ((r.st == PHS_CLOSE) && (n.plen == 8'h00) && (n.fill != 7'h00)))) begin
      n.ovalid = 1'b1;
      n.odata = {r.first, n.blk};
      n.first = 1'b0;
      n.blk = '0;
      n.fill = '0;
    end
    // Stream tail finished
    if ((r.st == PHS_CLOSE) && (n.plen == 8'h00) && (n.fill == 7'h00)) begin
      n.st = PHS_IDLE;
      n.nstreams = 16'(r.nstreams + 16'h0001);
    end
    // Close stream, end marker as six zero bits
    if (close_now) begin
      n.st = PHS_CLOSE;
      n.plen = r.marker ? PHS_EOS_LEN : 8'h00;
    end
    // Compose the fields of one item
    if (take) begin
      n.col_open = 1'b0;
      n.prev_ok = 1'b0;
      if (item_is_tag_in) begin
        n.evt_done = 1'b0;
        if (r.st == PHS_IDLE) begin
          {acc, al} = app(acc, al, 64'(item_tag_in), 7'(PHS_TAG_W));
          n.st = PHS_RUN;
          n.first = 1'b1;
          n.evcnt = 7'h01;
        end else begin
          {acc, al} = app(acc, al, 64'({PHS_ITAG_PFX, item_tag_in}), 7'(PHS_TAG_W + 3));
          n.evcnt = 7'(r.evcnt + 7'h01);
        end
      end else if (col_ok) begin
        if (new_col) begin
          {acc, al} = app(acc, al, 64'(item_ccol_in), 7'(PHS_CCOL_W));
        end
        {acc, al} = app(acc, al, 64'({item_col_last_in, nbr}), 7'h02);
        if (!nbr) begin
          {acc, al} = app(acc, al, 64'(item_qrow_in), 7'(PHS_QROW_W));
        end
        {acc, al} = app(acc, al, 64'(hm.code >> 5'(PHS_CODE_W - hm.len)), 7'(hm.len));
        for (int i = 0; i < 16; i++) begin
          if (hit_map[15-i] && !r.suppress) begin
            {acc, al} = app(acc, al, 64'(item_tot_in[63-4*i -: 4]), 7'(PHS_TOT_W));
          end
        end
        n.cur_ccol = item_ccol_in;
        n.col_open = !item_col_last_in;
        n.prev_qrow = item_qrow_in;
        n.prev_ok = !item_col_last_in;
      end else begin
        n.col_open = r.col_open;
        n.prev_ok = r.prev_ok;
      end
      if (item_event_end_in) begin
        n.evt_done = 1'b1;
      end
      n.pend = acc;
      n.plen = al;
    end
    // AXI write address and data, taken in either order
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      n.aw_done = 1'b1;
      n.awaddr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      n.w_done = 1'b1;
      n.wdata = s_axi_wdata_in;
      n.wstrb = s_axi_wstrb_in;
    end
    if (r.bvalid && s_axi_bready_in) begin
      n.bvalid = 1'b0;
    end
    if (n.aw_done && n.w_done && !r.bvalid) begin
      n.aw_done = 1'b0;
      n.w_done = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = PHS_RESP_OKAY;
      if (n.awaddr == PHS_ADDR_CONF) begin
        if (n.wstrb[0]) begin
          n.compress = n.wdata[PHS_CONF_COMPRESS];
          n.suppress = n.wdata[PHS_CONF_SUPPRESS];
          n.marker = n.wdata[PHS_CONF_MARKER];
        end
        if (n.wstrb[1]) begin
          n.ne = n.wdata[PHS_CONF_NE_LSB +: 6];
        end
      end else if (n.awaddr != PHS_ADDR_STAT) begin
        n.bresp = PHS_RESP_SLVERR;
      end
    end
    // AXI read
    if (r.rvalid && s_axi_rready_in) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      n.rvalid = 1'b1;
      n.rdata = '0;
      n.rresp = PHS_RESP_OKAY;
      if (s_axi_araddr_in == PHS_ADDR_CONF) begin
        n.rdata[PHS_CONF_COMPRESS] = r.compress;
        n.rdata[PHS_CONF_SUPPRESS] = r.suppress;
        n.rdata[PHS_CONF_MARKER] = r.marker;
        n.rdata[PHS_CONF_NE_LSB +: 6] = r.ne;
      end else if (s_axi_araddr_in == PHS_ADDR_STAT) begin
        n.rdata[PHS_STAT_BUSY] = r.st != PHS_IDLE;
        n.rdata[PHS_STAT_CNT_LSB +: 16] = r.nstreams;
      end else begin
        n.rresp = PHS_RESP_SLVERR;
      end
    end
  end

  // State register
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= PHS_IDLE;
      r.compress <= PHS_RST_COMPRESS;
      r.suppress <= PHS_RST_SUPPRESS;
      r.marker <= PHS_RST_MARKER;
      r.ne <= PHS_RST_NE;
    end else begin
      r <= n;
    end
  end

  // Stream opens with an 8-bit tag
  property p_tag_start;
    @(posedge clock_in) disable iff (!rst_n)
    (take && (r.st == PHS_IDLE)) |=> (r.plen == 8'h08) && r.first && (r.fill == 7'h00);
  endproperty
  a_tag_start: assert property (p_tag_start) else $error("stream did not open with tag");

  // Internal tag is eleven bits led by three ones
  property p_int_tag;
    @(posedge clock_in) disable iff (!rst_n)
    (take && item_is_tag_in && (r.st == PHS_RUN)) |=>
      (r.plen == 8'h0B) && (r.pend[127:125] == 3'b111);
  endproperty
  a_int_tag: assert property (p_int_tag) else $error("internal tag malformed");

  // Closing appends six zero bits only with the marker on
  property p_marker;
    @(posedge clock_in) disable iff (!rst_n)
    close_now |=> (r.st == PHS_CLOSE) && (r.plen == ($past(r.marker) ? 8'h06 : 8'h00));
  endproperty
  a_marker: assert property (p_marker) else $error("end marker length wrong");

  // Start bit of each block is set on the stream's first block only
  property p_start_bit;
    @(posedge clock_in) disable iff (!rst_n)
    (can_emit && n.ovalid && (n.fill == 7'h00) && (r.fill + r.plen != 8'h00)) |=>
      blk_valid_out && (blk_data_out[63] == $past(r.first)) && !r.first;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("stream start bit wrong");

  // A held block stays unchanged until taken
  property p_hold;
    @(posedge clock_in) disable iff (!rst_n)
    (blk_valid_out && !blk_ready_in) |=> blk_valid_out && $stable(blk_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("block changed while stalled");

  // A new column address is nonzero and below 56
  property p_ccol;
    @(posedge clock_in) disable iff (!rst_n)
    (take && !item_is_tag_in && new_col && col_ok) |=>
      (r.pend[127:122] != 6'h00) && (r.pend[127:122] <= PHS_CCOL_MAX);
  endproperty
  a_ccol: assert property (p_ccol) else $error("column address out of range");

  // Within a column the field opens with the final-row flag
  property p_last_flag;
    @(posedge clock_in) disable iff (!rst_n)
    (take && !item_is_tag_in && !new_col) |=>
      (r.pend[127] == $past(item_col_last_in)) && (r.pend[126] == $past(nbr));
  endproperty
  a_last_flag: assert property (p_last_flag) else $error("row flags wrong");

  // Raw map with widths dropped and neighbour row is 18 bits
  property p_suppress;
    @(posedge clock_in) disable iff (!rst_n)
    (take && !item_is_tag_in && !new_col && nbr && r.suppress && !r.compress) |=>
      (r.plen == 8'h12);
  endproperty
  a_suppress: assert property (p_suppress) else $error("suppressed length wrong");

  // Idle input at an event boundary ends the stream
  property p_close;
    @(posedge clock_in) disable iff (!rst_n)
    ((r.st == PHS_RUN) && r.evt_done && (r.plen == 8'h00) && !item_valid_in) |=>
      (r.st == PHS_CLOSE) ##[1:6] (r.st == PHS_IDLE || blk_valid_out);
  endproperty
  a_close: assert property (p_close) else $error("stream not ended");

  // Uncompressed map is exactly sixteen bits
  property p_raw;
    @(posedge clock_in) disable iff (!rst_n)
    !r.compress |-> (hm.len == PHS_RAW_LEN) && (hm.code[29:14] == hit_map);
  endproperty
  a_raw: assert property (p_raw) else $error("raw map length wrong");
endmodule

//--- test_pixel_hit_stream_encoder.sv
// Purpose: Self-checking bench for the hit stream encoder
// Assumes: Expected streams are rebuilt bit by bit from the field layout
// Notes: One task per scenario; blocks are compared whole
module test_pixel_hit_stream_encoder import phs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'h0, rst_n_in = 1'h0, item_valid_in = 1'h0, item_is_tag_in = 1'h0;
  logic item_event_end_in = 1'h0, item_col_last_in = 1'h0, blk_ready_in, stall = 1'h0;
  logic [7:0] item_tag_in = 8'h00, item_qrow_in = 8'h00;
  logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
  logic [5:0] item_ccol_in = 6'h00;
  logic [63:0] item_tot_in = 64'h0, blk_data_out;
  logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, rd;
  logic [3:0] s_axi_wstrb_in = 4'hF;
  logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
  logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0;
  logic item_ready_out, blk_valid_out, s_axi_awready_out, s_axi_wready_out;
  logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rs;
  int fail_count = 0, n_compared = 0, cur_col;
  int prev_row[64];
  logic cmp, sup, mk;
  bit eq[$];
  logic [63:0] xb[$];

  phs_stream_enc i_dut (.clock_in, .rst_n_in, .item_valid_in, .item_ready_out, .item_is_tag_in,
    .item_event_end_in, .item_tag_in, .item_ccol_in, .item_qrow_in, .item_col_last_in,
    .item_tot_in, .blk_valid_out, .blk_ready_in, .blk_data_out, .s_axi_awaddr_in,
    .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
    .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
    .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
    .s_axi_rvalid_out, .s_axi_rready_in);
  phs_sink_model i_sink (.clock_in, .blk_valid_in(blk_valid_out), .blk_data_in(blk_data_out),
    .stall_in(stall), .blk_ready_out(blk_ready_in));

  // 40 MHz clock
  initial forever #12.5 clock_in = !clock_in;

  task close_out();
    $display("compared %0d, unexpected %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Expected bits, MSB first
  function void put(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) eq.push_back(v[i]);
  endfunction

  function void put_el(input logic [1:0] e);
    if (e == 2'h1) put(32'h0, 1);
    else put(e, 2);
  endfunction

  // Tree: rows, then per row halves, pairs, pair maps
  function void put_map(input logic [15:0] m);
    logic [7:0] rw;
    logic [3:0] hf;
    put_el({|m[15:8], |m[7:0]});
    for (int r = 0; r < 2; r++) begin
      rw = r ? m[7:0] : m[15:8];
      if (rw != 8'h00) begin
        put_el({|rw[7:4], |rw[3:0]});
        for (int h = 0; h < 2; h++) begin
          hf = h ? rw[3:0] : rw[7:4];
          if (hf != 4'h0) put_el({|hf[3:2], |hf[1:0]});
        end
        for (int p = 0; p < 4; p++) if (rw[7 - 2 * p -: 2] != 2'h0) put_el(rw[7 - 2 * p -: 2]);
      end
    end
  endfunction

  // Close the stream: marker, zero fill, cut into blocks
  function void seal();
    logic [63:0] w;
    if (mk) put(32'h0, 6);
    while (eq.size() % 63 != 0) put(32'h0, 1);
    for (int k = 0; eq.size() > 0; k++) begin
      w[63] = k == 0;
      for (int i = 62; i >= 0; i--) w[i] = eq.pop_front();
      xb.push_back(w);
    end
  endfunction

  task item(input logic tg, e, l, input logic [7:0] g, q, input logic [5:0] c,
    input logic [63:0] t);
    logic ok;
    item_is_tag_in <= tg;
    item_event_end_in <= e;
    item_col_last_in <= l;
    item_tag_in <= g;
    item_qrow_in <= q;
    item_ccol_in <= c;
    item_tot_in <= t;
    item_valid_in <= 1'h1;
    do begin
      @(negedge clock_in);
      ok = item_ready_out === 1'h1;
      @(posedge clock_in);
    end while (!ok);
  endtask

  task tag(input logic [7:0] g, input logic first, e);
    if (first && eq.size() > 0) seal();
    if (first) put(g, 8);
    else put({3'h7, g}, 11);
    cur_col = -1;
    item(1'h1, e, 1'h0, g, 8'h00, 6'h00, {16{4'hF}});
  endtask

  task hit(input logic [5:0] c, input logic [7:0] q, input logic l, e, input logic [63:0] t);
    logic [15:0] m;
    logic nb;
    for (int i = 0; i < 16; i++) m[15 - i] = t[63 - 4 * i -: 4] != 4'hF;
    nb = c == cur_col && q == prev_row[c] + 1;
    if (c != cur_col) put(c, 6);
    put(l, 1);
    put(nb, 1);
    if (!nb) put(q, 8);
    if (cmp) put_map(m);
    else put(m, 16);
    for (int i = 0; i < 16 && !sup; i++) if (m[15 - i]) put(t[63 - 4 * i -: 4], 4);
    cur_col = l ? -1 : c;
    prev_row[c] = q;
    item(1'h0, e, l, 8'h00, q, c, t);
  endtask

  // Release input, wait for blocks, compare and look for extras
  task check_out();
    logic [63:0] got;
    item_valid_in <= 1'h0;
    seal();
    for (int k = 0; k < 3000 && i_sink.blks.size() < xb.size(); k++) @(posedge clock_in);
    while (xb.size() > 0) begin
      if (i_sink.blks.size() > 0) got = i_sink.blks.pop_front();
      else got = 64'hX;
      chk(got, xb.pop_front());
    end
    chk(64'(i_sink.blks.size()), 64'h0);
  endtask

  task axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'h1;
    s_axi_wvalid_in <= 1'h1;
    s_axi_bready_in <= 1'h1;
    do begin
      @(negedge clock_in);
      ta = s_axi_awvalid_in && s_axi_awready_out === 1'h1;
      tw = s_axi_wvalid_in && s_axi_wready_out === 1'h1;
      tb = s_axi_bvalid_out === 1'h1;
      rs = s_axi_bresp_out;
      @(posedge clock_in);
      if (ta) s_axi_awvalid_in <= 1'h0;
      if (tw) s_axi_wvalid_in <= 1'h0;
    end while (!tb);
    s_axi_bready_in <= 1'h0;
  endtask

  task axi_rd(input logic [7:0] a);
    logic ta, tb;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'h1;
    s_axi_rready_in <= 1'h1;
    do begin
      @(negedge clock_in);
      ta = s_axi_arvalid_in && s_axi_arready_out === 1'h1;
      tb = s_axi_rvalid_out === 1'h1;
      rd = s_axi_rdata_out;
      rs = s_axi_rresp_out;
      @(posedge clock_in);
      if (ta) s_axi_arvalid_in <= 1'h0;
    end while (!tb);
    s_axi_rready_in <= 1'h0;
  endtask

  task cfg(input logic c, s, m, input logic [5:0] n);
    cmp = c;
    sup = s;
    mk = m;
    axi_wr(PHS_ADDR_CONF, {18'h0, n, 5'h0, m, s, c});
    chk({62'h0, rs}, 64'h0);
  endtask

  task t_regs();
    axi_rd(PHS_ADDR_CONF);
    chk({32'h0, rd}, 64'h1005);
    axi_rd(8'h08);
    chk({30'h0, rs, rd}, {30'h0, PHS_RESP_SLVERR, 32'h0});
    axi_wr(8'h08, 32'h0);
    chk({62'h0, rs}, {62'h0, PHS_RESP_SLVERR});
    axi_wr(PHS_ADDR_STAT, 32'hFFFF_FFFF);
    chk({62'h0, rs}, 64'h0);
    axi_rd(PHS_ADDR_STAT);
    chk({30'h0, rs, rd}, 64'h0);
    $display("test regs done");
  endtask

  // Neighbor rows in column 55, stream ends near a block edge
  task t_single();
    cfg(1'h1, 1'h0, 1'h1, 6'h00);
    tag(8'hA5, 1'h1, 1'h0);
    item(1'h0, 1'h0, 1'h1, 8'h00, 8'h01, 6'h00, 64'h2FFF_FFFF_FFFF_FFFF);
    hit(6'h37, 8'h03, 1'h0, 1'h0, 64'h2FFF_FFFF_FEFF_FFFF);
    hit(6'h37, 8'h04, 1'h1, 1'h1, 64'h7FFF_FFFF_FFFF_FFFF);
    check_out();
    $display("test single done");
  endtask

  // Raw maps, widths dropped, no marker, slow sink
  task t_raw();
    stall <= 1'h1;
    cfg(1'h0, 1'h1, 1'h0, 6'h00);
    tag(8'h5A, 1'h1, 1'h0);
    hit(6'h01, 8'h05, 1'h0, 1'h0, 64'hF0F1_F2F3_FFFF_FFF4);
    hit(6'h01, 8'h06, 1'h1, 1'h0, 64'hFFFF_FFFF_0FFF_FFFF);
    hit(6'h02, 8'h00, 1'h1, 1'h1, 64'hFFFF_FFF8_FFFF_FFFF);
    check_out();
    stall <= 1'h0;
    $display("test raw done");
  endtask

  // Two events in the first stream: internal tag, empty event, limit
  task t_multi();
    stall <= 1'h1;
    cfg(1'h1, 1'h0, 1'h1, 6'h02);
    tag(8'h11, 1'h1, 1'h0);
    hit(6'h07, 8'h00, 1'h1, 1'h1, 64'h0123_4567_89AB_CDE0);
    tag(8'h22, 1'h0, 1'h1);
    tag(8'h33, 1'h1, 1'h0);
    hit(6'h08, 8'h09, 1'h1, 1'h1, 64'hFFFF_FFFF_FFFF_FFF9);
    check_out();
    axi_rd(PHS_ADDR_STAT);
    chk({30'h0, rs, rd}, 64'h0004_0000);
    stall <= 1'h0;
    $display("test multi done");
  endtask

  initial begin
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'h1;
    repeat (3) @(posedge clock_in);
    t_regs();
    t_single();
    t_raw();
    t_multi();
    close_out();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clock_in);
    fail_count++;
    close_out();
  end
endmodule
